// ==== design/act_pkg.sv ====
`default_nettype none
package act_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int PLL_SETTLE_MS   = 10;
    localparam int PLL_SETTLE_CYC  = (PLL_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHUTDOWN_TICKS  = 32;
    localparam int FRAC_SCALE      = 10000;
    localparam logic [27:0] PLL_ACC_CAP = 28'h4000000;

    // register offsets
    localparam logic [7:0] OFS_ROOT_SEL     = 8'h04;
    localparam logic [7:0] OFS_PLL_PR       = 8'h05;
    localparam logic [7:0] OFS_PLL_J        = 8'h06;
    localparam logic [7:0] OFS_PLL_D_HI     = 8'h07;
    localparam logic [7:0] OFS_PLL_D_LO     = 8'h08;
    localparam logic [7:0] OFS_FIRST_DIV    = 8'h0b;
    localparam logic [7:0] OFS_SECOND_DIV   = 8'h0c;
    localparam logic [7:0] OFS_OSR_HI       = 8'h0d;
    localparam logic [7:0] OFS_OSR_LO       = 8'h0e;
    localparam logic [7:0] OFS_GP_SEL       = 8'h19;
    localparam logic [7:0] OFS_GP_DIV       = 8'h1a;
    localparam logic [7:0] OFS_IF_SETUP     = 8'h1b;
    localparam logic [7:0] OFS_BCLK_SEL     = 8'h1d;
    localparam logic [7:0] OFS_BCLK_DIV     = 8'h1e;
    localparam logic [7:0] OFS_DAC_STATUS   = 8'h25;
    localparam logic [7:0] OFS_AUX_CTRL     = 8'h34;
    localparam logic [7:0] OFS_AUX_STATUS   = 8'h35;

    // field positions
    localparam int PLL_EN_BIT     = 7;
    localparam int PLL_MODE_BIT   = 6;
    localparam int DIV_EN_BIT     = 7;
    localparam int BCLK_DRIVE_BIT = 3;
    localparam int DAC_FLAG_BIT   = 7;
    localparam int MOD_FLAG_BIT   = 3;
    localparam int GP_OE_BIT      = 0;
    localparam int PLL_READY_BIT  = 0;

    // reset values
    localparam logic [7:0]  RST_PLL_PR  = 8'h11;
    localparam logic [5:0]  RST_PLL_J   = 6'h04;
    localparam logic [13:0] RST_PLL_D   = 14'h0000;
    localparam logic [6:0]  RST_DIV     = 7'h01;
    localparam logic [9:0]  RST_OSR     = 10'h080;
    localparam logic [7:0]  RST_BYTE    = 8'h00;

    // root clock source codes
    localparam logic [1:0] ROOT_MCLK = 2'h0;
    localparam logic [1:0] ROOT_BCLK = 2'h1;
    localparam logic [1:0] ROOT_GP   = 2'h2;
    localparam logic [1:0] ROOT_PLL  = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } act_bus_req_s;

    typedef struct packed {
        logic        en;
        logic [2:0]  p;
        logic [3:0]  r;
        logic [5:0]  j;
        logic [13:0] d;
    } act_pll_cfg_s;

    typedef enum logic [1:0] {DAC_OFF, DAC_RUN, DAC_SHUT} act_dac_state_e;

endpackage
`default_nettype wire

// ==== design/act_clock_tree.sv ====
// Functional notes
// - modulator clock is root over first times second divider; sample rate further over oversampling.
// - first divider reg 11 bits 6..0, second reg 12, oversampling 10 bits in 13/14.
// - bit 7 of regs 11 and 12 enable dividers; both needed before DAC powers up.
// - DAC power-down runs a shutdown sequence that needs both dividers running.
// - reg 37 bits 7 and 3 show DAC power status, read only.
// - when reg 27 bit 3 set, bit clock pin driven by source over reg 30 value.
// - reg 29 bits 1..0 pick processing clock or modulator clock for bit clock divider.
// - general-purpose pin may output its source divided by reg 26 value 1..128.
// - reg 25 bits 2..0 choose the source of the general-purpose clock divider.
// - reg 5 bit 7 switches the PLL on and off.
// - enabled PLL output equals input times R times J.D over P.
// - P in reg 5 bits 6..4 default 1; R in bits 3..0 default 1.
// - J in reg 6 bits 5..0, range 1 to 63, default 4; the code also stores and uses 0.
// - D is 14 bits, high part reg 7 bits 5..0, low part reg 8.
// - new D applies only when reg 8 write completes after reg 7.
// - PLL output usable only after a settling time of 10 ms.
// - PLL runs independently and may feed the general-purpose pin.
// - reg 4 bits 1..0 pick root from master, bit clock, gp pin or PLL.
// - root clock from any pin passes through the divider chain.
`default_nettype none

module act_tick_div #(
    parameter int W = 7
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // control
    input  wire logic         en,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] div,
    // divided enable
    output var  logic         tick_out
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] last;

    if (W < 2) begin : g_chk
        $error("act_tick_div: W must be at least 2");
    end

    // zero wraps to all ones: division by 2**W
    assign last = div - {{(W-1){1'b0}}, 1'b1};

    always_ff @(posedge clk) begin
        if (reset || !en) begin
            cnt_reg  <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (cnt_reg == last) begin
                    cnt_reg  <= '0;
                    tick_out <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // act_tick_div

module act_clock_tree #(
    parameter int PLL_SETTLE_CYCLES = act_pkg::PLL_SETTLE_CYC,
    parameter int SHUT_TICKS        = act_pkg::SHUTDOWN_TICKS
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // register port
    input  wire act_pkg::act_bus_req_s bus_req,
    output var  logic [7:0]            rdata,
    // clock pins
    input  wire logic                  mclk_in,
    input  wire logic                  bclk_in,
    output var  logic                  bclk_out,
    output var  logic                  bclk_oe,
    input  wire logic                  gp_in,
    output var  logic                  gp_out,
    output var  logic                  gp_oe,
    // DAC channel
    input  wire logic                  dac_power_up,
    output var  logic                  dac_running,
    output var  logic                  proc_tick,
    output var  logic                  mod_tick,
    output var  logic                  fs_tick
);
    import act_pkg::*;

    localparam int SW = $clog2(PLL_SETTLE_CYCLES + 1);
    localparam int CW = $clog2(SHUT_TICKS + 1);

    if (PLL_SETTLE_CYCLES < 1 || SHUT_TICKS < 1) begin : g_chk
        $error("act_clock_tree: counts must be at least 1");
    end

    // register storage
    logic [1:0]   root_sel_reg;
    logic         pll_mode_reg;
    act_pll_cfg_s pll_cfg_reg;
    logic [5:0]   d_hi_shadow_reg;
    logic         first_en_reg;
    logic [6:0]   first_val_reg;
    logic         second_en_reg;
    logic [6:0]   second_val_reg;
    logic [9:0]   osr_reg;
    logic [2:0]   gp_sel_reg;
    logic [6:0]   gp_div_reg;
    logic [7:0]   if_setup_reg;
    logic [7:0]   bclk_sel_reg;
    logic [6:0]   bclk_div_reg;
    logic [2:0]   aux_ctrl_reg;

    logic wr;
    logic [7:0] addr;
    logic [7:0] wd;
    assign wr   = bus_req.wr;
    assign addr = bus_req.addr;
    assign wd   = bus_req.wdata;

    always_ff @(posedge clk) begin
        if (reset) begin
            root_sel_reg    <= ROOT_MCLK;
            pll_mode_reg    <= 1'b0;
            pll_cfg_reg     <= {RST_PLL_PR, RST_PLL_J, RST_PLL_D};
            d_hi_shadow_reg <= RST_PLL_D[13:8];
            first_en_reg    <= 1'b0;
            first_val_reg   <= RST_DIV;
            second_en_reg   <= 1'b0;
            second_val_reg  <= RST_DIV;
            osr_reg         <= RST_OSR;
            gp_sel_reg      <= RST_BYTE[2:0];
            gp_div_reg      <= RST_DIV;
            if_setup_reg    <= RST_BYTE;
            bclk_sel_reg    <= RST_BYTE;
            bclk_div_reg    <= RST_DIV;
            aux_ctrl_reg    <= RST_BYTE[2:0];
        end else if (wr) begin
            case (addr)
                OFS_ROOT_SEL: begin
                    root_sel_reg <= wd[1:0];
                    pll_mode_reg <= wd[PLL_MODE_BIT];
                end
                OFS_PLL_PR: begin
                    pll_cfg_reg.en <= wd[PLL_EN_BIT];
                    pll_cfg_reg.p  <= wd[6:4];
                    pll_cfg_reg.r  <= wd[3:0];
                end
                OFS_PLL_J:    pll_cfg_reg.j <= wd[5:0];
                OFS_PLL_D_HI: d_hi_shadow_reg <= wd[5:0];
                OFS_PLL_D_LO: pll_cfg_reg.d <= {d_hi_shadow_reg, wd};
                OFS_FIRST_DIV: begin
                    first_en_reg  <= wd[DIV_EN_BIT];
                    first_val_reg <= wd[6:0];
                end
                OFS_SECOND_DIV: begin
                    second_en_reg  <= wd[DIV_EN_BIT];
                    second_val_reg <= wd[6:0];
                end
                OFS_OSR_HI:   osr_reg[9:8] <= wd[1:0];
                OFS_OSR_LO:   osr_reg[7:0] <= wd;
                OFS_GP_SEL:   gp_sel_reg <= wd[2:0];
                OFS_GP_DIV:   gp_div_reg <= wd[6:0];
                OFS_IF_SETUP: if_setup_reg <= wd;
                OFS_BCLK_SEL: bclk_sel_reg <= wd;
                OFS_BCLK_DIV: bclk_div_reg <= wd[6:0];
                OFS_AUX_CTRL: aux_ctrl_reg <= wd[2:0];
                default: ;
            endcase
        end
    end

    // pin inputs: three stages, level accepted once stages two and three agree
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_lvl;
    logic [2:0] pin_lvl_d;
    logic [2:0] pin_edge;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1    <= 3'h0;
            pin_s2    <= 3'h0;
            pin_s3    <= 3'h0;
            pin_lvl   <= 3'h0;
            pin_lvl_d <= 3'h0;
        end else begin
            pin_s1    <= {gp_in, bclk_in, mclk_in};
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_lvl_d <= pin_lvl;
            for (int i = 0; i < 3; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_lvl[i] <= pin_s3[i];
                end
            end
        end
    end

    assign pin_edge = pin_lvl & ~pin_lvl_d;

    // fractional synthesizer as a rate accumulator, at most one tick per cycle
    logic        synth_input_clock;
    logic [3:0]  p_val;
    logic [4:0]  r_val;
    logic [27:0] pll_inc;
    logic [27:0] pll_thresh;
    logic [27:0] pll_acc_reg;
    logic [27:0] acc_add;
    logic [27:0] acc_sub;
    logic        pll_due;
    logic        pll_tick_reg;
    logic        pll_ready_reg;
    logic [SW-1:0] settle_cnt_reg;

    assign synth_input_clock = (aux_ctrl_reg[2:1] == ROOT_BCLK) ? pin_edge[1] :
                               (aux_ctrl_reg[2:1] == ROOT_GP)   ? pin_edge[2] : pin_edge[0];
    assign p_val      = {pll_cfg_reg.p == 3'h0, pll_cfg_reg.p};
    assign r_val      = {pll_cfg_reg.r == 4'h0, pll_cfg_reg.r};
    assign pll_inc    = 28'(r_val) * (28'(pll_cfg_reg.j) * 28'(FRAC_SCALE)
                        + 28'(pll_cfg_reg.d));
    assign pll_thresh = 28'(p_val) * 28'(FRAC_SCALE);
    assign pll_due    = pll_acc_reg >= pll_thresh;
    assign acc_add    = (synth_input_clock && pll_acc_reg < PLL_ACC_CAP) ? pll_inc : 28'h0;
    assign acc_sub    = pll_due ? pll_thresh : 28'h0;

    always_ff @(posedge clk) begin
        if (reset || !pll_cfg_reg.en) begin
            pll_acc_reg  <= 28'h0;
            pll_tick_reg <= 1'b0;
        end else begin
            pll_acc_reg  <= pll_acc_reg + acc_add - acc_sub;
            pll_tick_reg <= pll_due && pll_ready_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !pll_cfg_reg.en) begin
            settle_cnt_reg <= '0;
            pll_ready_reg  <= 1'b0;
        end else if (!pll_ready_reg) begin
            settle_cnt_reg <= settle_cnt_reg + {{(SW-1){1'b0}}, 1'b1};
            if (settle_cnt_reg == SW'(PLL_SETTLE_CYCLES - 1)) begin
                pll_ready_reg <= 1'b1;
            end
        end
    end

    // root clock and divider chain
    logic root_codec_clock;
    always_comb begin
        case (root_sel_reg)
            ROOT_MCLK: root_codec_clock = pin_edge[0];
            ROOT_BCLK: root_codec_clock = pin_edge[1];
            ROOT_GP:   root_codec_clock = pin_edge[2];
            ROOT_PLL:  root_codec_clock = pll_tick_reg;
            default:   root_codec_clock = 1'b0;
        endcase
    end

    act_tick_div #(.W(7)) u_first (
        .clk      (clk),
        .reset    (reset),
        .en       (first_en_reg),
        .tick_in  (root_codec_clock),
        .div      (first_val_reg),
        .tick_out (proc_tick)
    );

    act_tick_div #(.W(7)) u_second (
        .clk      (clk),
        .reset    (reset),
        .en       (second_en_reg),
        .tick_in  (proc_tick),
        .div      (second_val_reg),
        .tick_out (mod_tick)
    );

    act_tick_div #(.W(10)) u_osr (
        .clk      (clk),
        .reset    (reset),
        .en       (first_en_reg && second_en_reg),
        .tick_in  (mod_tick),
        .div      (osr_reg),
        .tick_out (fs_tick)
    );

    // bit clock and general-purpose clock outputs
    logic bitclk_divider_source;
    logic gpclk_divider_source;
    assign bitclk_divider_source = (bclk_sel_reg[1:0] == 2'h1) ? mod_tick : proc_tick;

    always_comb begin
        case (gp_sel_reg)
            3'h0:    gpclk_divider_source = root_codec_clock;
            3'h1:    gpclk_divider_source = pll_tick_reg;
            3'h2:    gpclk_divider_source = proc_tick;
            3'h3:    gpclk_divider_source = mod_tick;
            3'h4:    gpclk_divider_source = fs_tick;
            3'h5:    gpclk_divider_source = bclk_out;
            default: gpclk_divider_source = root_codec_clock;
        endcase
    end

    act_tick_div #(.W(7)) u_bclk (
        .clk      (clk),
        .reset    (reset),
        .en       (if_setup_reg[BCLK_DRIVE_BIT]),
        .tick_in  (bitclk_divider_source),
        .div      (bclk_div_reg),
        .tick_out (bclk_out)
    );

    act_tick_div #(.W(7)) u_gp (
        .clk      (clk),
        .reset    (reset),
        .en       (aux_ctrl_reg[GP_OE_BIT]),
        .tick_in  (gpclk_divider_source),
        .div      (gp_div_reg),
        .tick_out (gp_out)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            bclk_oe <= 1'b0;
            gp_oe   <= 1'b0;
        end else begin
            bclk_oe <= if_setup_reg[BCLK_DRIVE_BIT];
            gp_oe   <= aux_ctrl_reg[GP_OE_BIT];
        end
    end

    // DAC power sequencing; shutdown counts modulator ticks, so it stalls without them
    act_dac_state_e dac_state_reg;
    logic [CW-1:0]  shut_cnt_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            dac_state_reg <= DAC_OFF;
            shut_cnt_reg  <= '0;
        end else begin
            case (dac_state_reg)
                DAC_OFF: begin
                    shut_cnt_reg <= '0;
                    if (dac_power_up && first_en_reg && second_en_reg) begin
                        dac_state_reg <= DAC_RUN;
                    end
                end
                DAC_RUN: begin
                    if (!dac_power_up) begin
                        dac_state_reg <= DAC_SHUT;
                    end
                end
                DAC_SHUT: begin
                    if (mod_tick) begin
                        shut_cnt_reg <= shut_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
                        if (shut_cnt_reg == CW'(SHUT_TICKS - 1)) begin
                            dac_state_reg <= DAC_OFF;
                        end
                    end
                end
                default: dac_state_reg <= DAC_OFF;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dac_running <= 1'b0;
        end else begin
            dac_running <= (dac_state_reg == DAC_RUN);
        end
    end

    // register read, data valid the cycle after the strobe only
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (addr)
            OFS_ROOT_SEL:   rd_mux = {1'b0, pll_mode_reg, 4'h0, root_sel_reg};
            OFS_PLL_PR:     rd_mux = {pll_cfg_reg.en, pll_cfg_reg.p, pll_cfg_reg.r};
            OFS_PLL_J:      rd_mux = {2'h0, pll_cfg_reg.j};
            OFS_PLL_D_HI:   rd_mux = {2'h0, d_hi_shadow_reg};
            OFS_PLL_D_LO:   rd_mux = pll_cfg_reg.d[7:0];
            OFS_FIRST_DIV:  rd_mux = {first_en_reg, first_val_reg};
            OFS_SECOND_DIV: rd_mux = {second_en_reg, second_val_reg};
            OFS_OSR_HI:     rd_mux = {6'h00, osr_reg[9:8]};
            OFS_OSR_LO:     rd_mux = osr_reg[7:0];
            OFS_GP_SEL:     rd_mux = {5'h00, gp_sel_reg};
            OFS_GP_DIV:     rd_mux = {1'b0, gp_div_reg};
            OFS_IF_SETUP:   rd_mux = if_setup_reg;
            OFS_BCLK_SEL:   rd_mux = bclk_sel_reg;
            OFS_BCLK_DIV:   rd_mux = {1'b0, bclk_div_reg};
            OFS_DAC_STATUS: begin
                rd_mux[DAC_FLAG_BIT] = (dac_state_reg != DAC_OFF);
                rd_mux[MOD_FLAG_BIT] = (dac_state_reg != DAC_OFF);
            end
            OFS_AUX_CTRL:   rd_mux = {5'h00, aux_ctrl_reg};
            OFS_AUX_STATUS: rd_mux[PLL_READY_BIT] = pll_ready_reg;
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_frac_hold_hi: assert property (wr && addr == OFS_PLL_D_HI |=> $stable(pll_cfg_reg.d))
        else $error("fraction changed on high-part write");
    a_frac_commit: assert property (wr && addr == OFS_PLL_D_LO
        |=> pll_cfg_reg.d == {$past(d_hi_shadow_reg), $past(wd)})
        else $error("fraction not committed on low-part write");
    a_pll_off_quiet: assert property (!pll_cfg_reg.en |=> !pll_tick_reg)
        else $error("synth tick while disabled");
    a_pll_settle_wait: assert property ($rose(pll_cfg_reg.en) |-> !pll_ready_reg ##1 !pll_tick_reg)
        else $error("synth usable before settling");
    a_dac_needs_div: assert property (dac_state_reg == DAC_OFF ##1 dac_state_reg == DAC_RUN
        |-> $past(first_en_reg) && $past(second_en_reg))
        else $error("DAC up without dividers");
    a_shut_flags_up: assert property (dac_state_reg == DAC_SHUT && bus_req.rd
        && addr == OFS_DAC_STATUS |=> rdata[DAC_FLAG_BIT] && rdata[MOD_FLAG_BIT])
        else $error("status shows down during shutdown");
    a_mod_from_proc: assert property (mod_tick |-> $past(proc_tick) && $past(second_en_reg))
        else $error("modulator tick without processing tick");
    a_fs_from_mod: assert property (fs_tick |-> $past(mod_tick))
        else $error("sample tick without modulator tick");
    a_bclk_quiet: assert property (!if_setup_reg[BCLK_DRIVE_BIT] |=> !bclk_out)
        else $error("bit clock driven while disabled");
    a_rdata_idle: assert property (!bus_req.rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");

    c_pll_ready: cover property ($rose(pll_ready_reg));
    c_shutdown_done: cover property (dac_state_reg == DAC_SHUT ##1 dac_state_reg == DAC_OFF);
    c_frac_update: cover property (wr && addr == OFS_PLL_D_HI ##1 wr && addr == OFS_PLL_D_LO);
    c_sample_tick: cover property (fs_tick);

endmodule // act_clock_tree
`default_nettype wire

// ==== test/act_clock_tree_tb.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import act_pkg::*;

    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    act_bus_req_s         req = '0;
    logic [7:0]           rdata;
    logic                 mclk_in = 1'b0, bclk_in = 1'b0, gp_in = 1'b0, dac_power_up = 1'b0;
    logic                 bclk_out, bclk_oe, gp_out, gp_oe, dac_running;
    logic                 proc_tick, mod_tick, fs_tick;
    logic [7:0]           exp_q[$];
    logic                 rd_q = 1'b0;
    int                   err_total = 0, checked = 0;
    int                   n_proc, n_mod, n_fs, n_bclk, n_gp, nf;
    logic [7:0]           ofs[17] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c, 8'h0d,
                                      8'h0e, 8'h19, 8'h1a, 8'h1b, 8'h1d, 8'h1e, 8'h25, 8'h00,
                                      8'h40};
    logic [7:0]           rst[17] = '{8'h00, 8'h11, 8'h04, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00,
                                      8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
                                      8'h00};

    act_clock_tree #(.PLL_SETTLE_CYCLES(20), .SHUT_TICKS(4)) dut (
        .clk(clk), .reset(reset), .bus_req(req), .rdata(rdata),
        .mclk_in(mclk_in), .bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
        .gp_in(gp_in), .gp_out(gp_out), .gp_oe(gp_oe), .dac_power_up(dac_power_up),
        .dac_running(dac_running), .proc_tick(proc_tick), .mod_tick(mod_tick),
        .fs_tick(fs_tick)
    );

    always #4 clk = ~clk;

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp({24'h0, got}, {24'h0, exp}, "read data");
    endtask

    // read data stands only in the cycle after the read strobe
    always @(posedge clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) cmp(0, 1, "unexpected read");
            else cmp_rd(rdata, exp_q.pop_front());
        end
        rd_q <= req.rd && !reset;
    end

    always @(posedge clk) begin
        if (proc_tick === 1'b1) n_proc++;
        if (mod_tick === 1'b1) n_mod++;
        if (fs_tick === 1'b1) n_fs++;
        if (bclk_out === 1'b1) n_bclk++;
        if (gp_out === 1'b1) n_gp++;
    end

    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
        req <= {a, d, w, ~w};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0);
    endtask

    // pin edges (0 master, 1 bit clock, 2 gp), each level held four cycles, then drain
    task automatic edges(input int n, input int pin = 0);
        repeat (n) begin
            mclk_in <= (pin == 0);
            bclk_in <= (pin == 1);
            gp_in   <= (pin == 2);
            repeat (4) @(posedge clk);
            {gp_in, bclk_in, mclk_in} <= 3'h0;
            repeat (4) @(posedge clk);
        end
        repeat (12) @(posedge clk);
    endtask

    task automatic clr;
        {n_proc, n_mod, n_fs, n_bclk, n_gp} = 160'h0;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report;
    end

    initial begin
        void'($urandom(55));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h3f);
        wr(8'h25, 8'hff);
        rd(8'h25, 8'h00);
        wr(8'h07, 8'h15);
        rd(8'h08, 8'h00);
        wr(8'h08, 8'hab);
        rd(8'h08, 8'hab);
        rd(8'h07, 8'h15);
        wr(8'h07, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h06, 8'h04);
        $display("registers done");
        nf = 1 << $urandom_range(0, 2);
        wr(8'h0b, 8'h80 | nf[7:0]);
        wr(8'h0c, 8'h81);
        wr(8'h0e, 8'h04);
        wr(8'h1b, 8'h08);
        wr(8'h1d, 8'h01);
        wr(8'h1e, 8'h05);
        wr(8'h34, 8'h01);
        wr(8'h19, 8'h02);
        wr(8'h1a, 8'h04);
        cmp(bclk_oe, 1, "bclk enable");
        cmp(gp_oe, 1, "gp enable");
        clr;
        edges(40);
        cmp(n_proc, 40 / nf, "processing ticks");
        cmp(n_mod, 40 / nf, "modulator ticks");
        cmp(n_fs, 10 / nf, "sample ticks");
        cmp(n_bclk, 8 / nf, "bit clock pulses");
        cmp(n_gp, 10 / nf, "gp clock pulses");
        $display("divider chain done");
        dac_power_up <= 1'b1;
        repeat (3) @(posedge clk);
        cmp(dac_running, 1, "dac running");
        rd(8'h25, 8'h88);
        dac_power_up <= 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h25, 8'h88);
        edges(20);
        rd(8'h25, 8'h00);
        cmp(dac_running, 0, "dac stopped");
        $display("dac power done");
        wr(8'h0b, 8'h81);
        wr(8'h04, 8'h03);
        wr(8'h19, 8'h01);
        wr(8'h1a, 8'h08);
        wr(8'h05, 8'h91);
        repeat (25) @(posedge clk);
        rd(8'h35, 8'h01);
        clr;
        edges(10);
        cmp(n_proc, 40, "pll ticks");
        cmp(n_gp, 5, "pll on gp pin");
        wr(8'h0c, 8'h01);
        wr(8'h0b, 8'h01);
        wr(8'h05, 8'h11);
        rd(8'h35, 8'h00);
        $display("pll done");
        wr(8'h04, 8'h02);
        wr(8'h19, 8'h00);
        wr(8'h1a, 8'h02);
        wr(8'h0b, 8'h80);
        wr(8'h34, 8'h00);
        @(posedge clk);
        cmp(gp_oe, 0, "gp disable");
        wr(8'h34, 8'h01);
        clr;
        edges(4, 1);
        cmp(n_gp, 0, "root ignores bit clock pin");
        edges(130, 2);
        cmp(n_proc, 1, "first divider at zero");
        cmp(n_gp, 65, "root on gp pin");
        $display("pin root done");
        repeat (3) @(posedge clk);
        cmp(exp_q.size(), 0, "reads left over");
        final_report;
    end
endmodule // testbench
`default_nettype wire
